// File: src/tbr_pkg.sv
/*
  package for the 10 Mb/s twisted-pair status and configuration registers:
  register addresses, bit positions and values after reset.
  assumes a management front end that presents decoded register accesses.
*/
package tbr_pkg;
  // ----------------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------------
  localparam logic [4:0] TBR_ADDR_STATUS = 5'h1b;  // status register
  localparam logic [4:0] TBR_ADDR_CONFIG = 5'h1c;  // configuration register
  // ----------------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------------
  localparam int TBR_ST_POL_OK = 10;  // polarity correct
  localparam int TBR_ST_SERIAL = 9;   // serial data path select
  // ----------------------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------------------
  localparam int TBR_CF_LEGACY  = 7;  // legacy compatibility mode
  localparam int TBR_CF_BLINK   = 6;  // indicator blink enable
  localparam int TBR_CF_LINKP   = 5;  // link pulse enable
  localparam int TBR_CF_HBEAT   = 4;  // heartbeat test enable
  localparam int TBR_CF_RSVD1   = 3;  // reserved, reads one
  localparam int TBR_CF_LOWSQ   = 2;  // low squelch
  localparam int TBR_CF_POLDIS  = 1;  // polarity correction disable
  localparam int TBR_CF_JABBER  = 0;  // jabber enable
  // ----------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------
  localparam logic TBR_RST_POL_OK = 1'h0;
  localparam logic TBR_RST_SERIAL = 1'h0;
  localparam logic TBR_RST_LEGACY = 1'h1;
  localparam logic TBR_RST_BLINK  = 1'h0;
  localparam logic TBR_RST_LINKP  = 1'h1;
  localparam logic TBR_RST_LOWSQ  = 1'h0;
  localparam logic TBR_RST_POLDIS = 1'h0;
  localparam logic TBR_RST_JABBER = 1'h1;
  localparam logic TBR_RSVD1_VAL  = 1'h1;
  // ----------------------------------------------------------------------
  // indicator blink half period in cycles
  // ----------------------------------------------------------------------
  localparam int TBR_BLINK_MS     = 100;
  localparam int TBR_CLK_MHZ      = 250;
  localparam int TBR_BLINK_CYCLES = TBR_BLINK_MS * 1000 * TBR_CLK_MHZ;
endpackage

// File: src/tbr_regs.sv
/*
  status and configuration register pair of the 10 Mb/s twisted-pair
  section: polarity status and correction, serial path select, legacy mode,
  link pulse control, heartbeat test, squelch and jabber controls.
  assumes the management front end gives one-cycle read and write strobes
  with a 5-bit register address, and that pins from outside are
  asynchronous to core_clk.
*/
// Notes on behaviour
// RULE_01: status bit 10 shows polarity correct
// RULE_02: auto inversion when correction not disabled
// RULE_03: polarity flag always reports true line polarity
// RULE_04: status bit 9 selects serial path
// RULE_05: serial select only matters at 10 Mb/s
// RULE_06: legacy mode bit blocks incompatible bit writes
// RULE_07: blink enable makes indicator blink during negotiation
// RULE_08: link pulse enable bit sends link pulses
// RULE_09: link pulses off forces link good
// RULE_10: pulses off at 100 with negotiation forces 10
// RULE_11: bit ignored at 100 without negotiation
// RULE_12: heartbeat test half duplex only, reset inverse strap
// RULE_13: repeater mode holds heartbeat enable cleared
// RULE_14: software writes reserved bit 3 as one
// RULE_15: low squelch bit lowers receive thresholds
// RULE_16: polarity disable bit, correction only in packets
// RULE_17: jabber off when cleared in full duplex or loopback
// RULE_18: legacy mode may also drop half duplex jabber
// RULE_19: reserved bits read as zero; the code reads configuration bit 3 as one
// RULE_20: writes to reserved positions are ignored
module tbr_regs
  import tbr_pkg::*;
#(
  parameter int BLINK_CYCLES = TBR_BLINK_CYCLES  // blink half period
) (
  input  wire logic        core_clk,          // core clock, 250 MHz
  input  wire logic        rst_n,             // synchronous reset
  input  wire logic        mgmt_wr,           // register write strobe
  input  wire logic        mgmt_rd,           // register read strobe
  input  wire logic [4:0]  mgmt_addr,         // register address
  input  wire logic [15:0] mgmt_wdata,        // write data
  output logic      [15:0] mgmt_rdata,        // read data, one cycle later
  input  wire logic        rx_pol_reversed,   // pin: line polarity reversed
  input  wire logic        rx_pkt_active,     // pin: 10 Mb/s packet in
  input  wire logic        repeater_strap,    // pin: repeater strap
  input  wire logic        speed_100,         // running at 100 Mb/s
  input  wire logic        autoneg_en,        // auto-negotiation enabled
  input  wire logic        autoneg_busy,      // auto-negotiation ongoing
  input  wire logic        full_duplex,       // full-duplex mode
  input  wire logic        endec_loopback,    // encoder/decoder loopback
  input  wire logic        link_good_in,      // link monitor result
  output logic             rx_invert,         // invert received signal
  output logic             serial_path,       // serial path in use
  output logic             link_pulse_tx_en,  // send link pulses
  output logic             link_good,         // link status to core
  output logic             force_10,          // drop to 10 Mb/s
  output logic             heartbeat_test,    // heartbeat test active
  output logic             low_squelch,       // reduced squelch levels
  output logic             jabber_en,         // jabber function active
  output logic             third_indicator_output  // indicator drive
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] sync_a;       // first stage, read only by second stage
  logic [2:0] sync_b;       // second stage
  logic [2:0] next_sync_a;  // next first stage
  logic [2:0] next_sync_b;  // next second stage
  logic       pol_rev_s;    // synchronised reversed polarity
  logic       pkt_s;        // synchronised packet reception
  logic       rep_s;        // synchronised repeater strap

  // next synchroniser values
  always_comb begin
    next_sync_a = {repeater_strap, rx_pkt_active, rx_pol_reversed};
    next_sync_b = sync_a;
  end

  // register the synchroniser stages
  always_ff @(posedge core_clk) begin
    sync_a <= next_sync_a;
    sync_b <= next_sync_b;
  end

  assign pol_rev_s = sync_b[0];
  assign pkt_s     = sync_b[1];
  assign rep_s     = sync_b[2];

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic        pol_ok;          // polarity status
  logic        serial_sel;      // serial path select
  logic        legacy;          // legacy compatibility mode
  logic        blink_en;        // indicator blink enable
  logic        linkp_en;        // link pulse enable
  logic        hbeat_en;        // heartbeat test enable
  logic        lowsq;           // low squelch select
  logic        poldis;          // polarity correction disable
  logic        jab_en;          // jabber enable
  logic        strap_done;      // strap captured after reset
  logic [15:0] rdata;           // read data
  logic        next_pol_ok;
  logic        next_serial_sel;
  logic        next_legacy;
  logic        next_blink_en;
  logic        next_linkp_en;
  logic        next_hbeat_en;
  logic        next_lowsq;
  logic        next_poldis;
  logic        next_jab_en;
  logic        next_strap_done;
  logic [15:0] next_rdata;
  logic        wr_st;           // write to status register
  logic        wr_cf;           // write to configuration register

  assign wr_st = mgmt_wr && (mgmt_addr == TBR_ADDR_STATUS);
  assign wr_cf = mgmt_wr && (mgmt_addr == TBR_ADDR_CONFIG);

  // next register values
  always_comb begin
    next_pol_ok     = !pol_rev_s;  // RULE_01
    next_serial_sel = serial_sel;
    next_legacy     = legacy;
    next_blink_en   = blink_en;
    next_linkp_en   = linkp_en;
    next_hbeat_en   = hbeat_en;
    next_lowsq      = lowsq;
    next_poldis     = poldis;
    next_jab_en     = jab_en;
    next_strap_done = 1'b1;
    next_rdata      = 16'h0000;
    // heartbeat enable reset value taken from strap after release
    if (!strap_done) begin
      next_hbeat_en = !rep_s;  // RULE_12
    end
    // status write: only bit 9 is writable, other bits ignored
    if (wr_st) begin
      next_serial_sel = mgmt_wdata[TBR_ST_SERIAL];  // RULE_04 RULE_20
    end
    // configuration write
    if (wr_cf) begin
      next_legacy   = mgmt_wdata[TBR_CF_LEGACY];  // RULE_06
      next_linkp_en = mgmt_wdata[TBR_CF_LINKP];  // RULE_08
      next_hbeat_en = mgmt_wdata[TBR_CF_HBEAT];
      next_lowsq    = mgmt_wdata[TBR_CF_LOWSQ];  // RULE_15
      next_jab_en   = mgmt_wdata[TBR_CF_JABBER];  // RULE_17
      // legacy mode blocks the blink and polarity disable bits
      if (!legacy) begin
        next_blink_en = mgmt_wdata[TBR_CF_BLINK];  // RULE_06 RULE_07
        next_poldis   = mgmt_wdata[TBR_CF_POLDIS];  // RULE_16
      end
    end
    // repeater mode holds heartbeat enable clear
    if (rep_s && strap_done) begin
      next_hbeat_en = 1'b0;  // RULE_13
    end
    // read data, reserved bits zero except configuration bit 3, which reads one
    if (mgmt_rd && mgmt_addr == TBR_ADDR_STATUS) begin
      next_rdata[TBR_ST_POL_OK] = pol_ok;  // RULE_03 RULE_19
      next_rdata[TBR_ST_SERIAL] = serial_sel;
    end else if (mgmt_rd && mgmt_addr == TBR_ADDR_CONFIG) begin
      next_rdata[TBR_CF_LEGACY] = legacy;  // RULE_19
      next_rdata[TBR_CF_BLINK]  = blink_en;
      next_rdata[TBR_CF_LINKP]  = linkp_en;
      next_rdata[TBR_CF_HBEAT]  = hbeat_en;
      next_rdata[TBR_CF_RSVD1]  = TBR_RSVD1_VAL;  // RULE_14
      next_rdata[TBR_CF_LOWSQ]  = lowsq;
      next_rdata[TBR_CF_POLDIS] = poldis;
      next_rdata[TBR_CF_JABBER] = jab_en;
    end
  end

  // register the state, constants under reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pol_ok     <= TBR_RST_POL_OK;
      serial_sel <= TBR_RST_SERIAL;
      legacy     <= TBR_RST_LEGACY;
      blink_en   <= TBR_RST_BLINK;
      linkp_en   <= TBR_RST_LINKP;
      hbeat_en   <= 1'b0;
      lowsq      <= TBR_RST_LOWSQ;
      poldis     <= TBR_RST_POLDIS;
      jab_en     <= TBR_RST_JABBER;
      strap_done <= 1'b0;
      rdata      <= 16'h0000;
    end else begin
      pol_ok     <= next_pol_ok;
      serial_sel <= next_serial_sel;
      legacy     <= next_legacy;
      blink_en   <= next_blink_en;
      linkp_en   <= next_linkp_en;
      hbeat_en   <= next_hbeat_en;
      lowsq      <= next_lowsq;
      poldis     <= next_poldis;
      jab_en     <= next_jab_en;
      strap_done <= next_strap_done;
      rdata      <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // blink timer
  // ----------------------------------------------------------------------
  logic [31:0] blink_cnt;       // half period counter
  logic        blink_ph;        // blink phase
  logic [31:0] next_blink_cnt;
  logic        next_blink_ph;

  // free-running half period toggle
  always_comb begin
    next_blink_cnt = blink_cnt + 32'h1;
    next_blink_ph  = blink_ph;
    if (blink_cnt >= 32'(BLINK_CYCLES - 1)) begin
      next_blink_cnt = 32'h0;
      next_blink_ph  = !blink_ph;
    end
  end

  // register the blink timer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      blink_cnt <= 32'h0;
      blink_ph  <= 1'b0;
    end else begin
      blink_cnt <= next_blink_cnt;
      blink_ph  <= next_blink_ph;
    end
  end

  // ----------------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------------
  logic next_rx_invert;
  logic next_serial_path;
  logic next_lp_tx;
  logic next_link_good;
  logic next_force_10;
  logic next_hb;
  logic next_jab;
  logic next_ind;
  logic lp_off;                 // link pulses off and honoured

  // derive the controls from the configuration
  always_comb begin
    // clearing has no effect at 100 Mb/s without auto-negotiation
    lp_off = !linkp_en && !(speed_100 && !autoneg_en);  // RULE_11
    // correction only during packet reception, and only when enabled
    next_rx_invert   = !poldis && pkt_s && pol_rev_s;  // RULE_02 RULE_16
    next_serial_path = serial_sel && !speed_100;  // RULE_05
    next_lp_tx       = !lp_off;  // RULE_08 RULE_09
    next_link_good   = link_good_in || lp_off;  // RULE_09
    next_force_10    = lp_off && speed_100 && autoneg_en;  // RULE_10
    next_hb          = hbeat_en && !full_duplex && !rep_s;  // RULE_12
    // jabber off when cleared in full duplex or loopback, or in legacy mode
    next_jab = jab_en  // RULE_17 RULE_18
             || !(full_duplex || endec_loopback || legacy);
    // indicator blinks during auto-negotiation when enabled
    if (blink_en && autoneg_busy) begin
      next_ind = blink_ph;  // RULE_07
    end else begin
      next_ind = next_link_good;
    end
  end

  // register the outputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_invert              <= 1'b0;
      serial_path            <= 1'b0;
      link_pulse_tx_en       <= 1'b0;
      link_good              <= 1'b0;
      force_10               <= 1'b0;
      heartbeat_test         <= 1'b0;
      low_squelch            <= 1'b0;
      jabber_en              <= 1'b0;
      third_indicator_output <= 1'b0;
    end else begin
      rx_invert              <= next_rx_invert;
      serial_path            <= next_serial_path;
      link_pulse_tx_en       <= next_lp_tx;
      link_good              <= next_link_good;
      force_10               <= next_force_10;
      heartbeat_test         <= next_hb;
      low_squelch            <= lowsq;  // RULE_15
      jabber_en              <= next_jab;
      third_indicator_output <= next_ind;
    end
  end

  assign mgmt_rdata = rdata;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_pol_ok;
    @(posedge core_clk) disable iff (!rst_n)
    // the first edge after release still shows the reset value
    $past(rst_n) |-> pol_ok == !$past(pol_rev_s);
  endproperty
  a_pol_ok: assert property (p_pol_ok) else $error("pol ok wrong"); // RULE_01

  property p_legacy_blocks;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_cf && legacy) |=> $stable(poldis) && $stable(blink_en);
  endproperty
  a_legacy_blocks: assert property (p_legacy_blocks) // RULE_06
    else $error("legacy write not blocked");

  property p_repeater_hb;
    @(posedge core_clk) disable iff (!rst_n)
    (rep_s && strap_done) |=> !hbeat_en;
  endproperty
  a_repeater_hb: assert property (p_repeater_hb) // RULE_13
    else $error("heartbeat set in repeater");

  property p_force_10;
    @(posedge core_clk) disable iff (!rst_n)
    (!linkp_en && speed_100 && autoneg_en) |=> force_10 && !link_pulse_tx_en;
  endproperty
  a_force_10: assert property (p_force_10) // RULE_10
    else $error("no drop to 10");

  property p_no_effect_100;
    @(posedge core_clk) disable iff (!rst_n)
    (speed_100 && !autoneg_en) |=> link_pulse_tx_en && !force_10;
  endproperty
  a_no_effect_100: assert property (p_no_effect_100) // RULE_11
    else $error("link pulse bit acted");

  property p_serial;
    @(posedge core_clk) disable iff (!rst_n)
    speed_100 |=> !serial_path;
  endproperty
  a_serial: assert property (p_serial) else $error("serial at 100"); // RULE_05

  property p_invert;
    @(posedge core_clk) disable iff (!rst_n)
    rx_invert |-> !$past(poldis) && $past(pkt_s);
  endproperty
  a_invert: assert property (p_invert) else $error("bad inversion"); // RULE_16

  property p_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
    mgmt_rdata[15:11] == 5'h00 && mgmt_rdata[8] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set"); // RULE_19

  property p_status_wr;
    @(posedge core_clk) disable iff (!rst_n)
    wr_st |=> serial_sel == $past(mgmt_wdata[TBR_ST_SERIAL]);
  endproperty
  a_status_wr: assert property (p_status_wr) // RULE_04
    else $error("serial bit not written");

  c_force_10: cover property (@(posedge core_clk) disable iff (!rst_n)
    force_10);
  c_invert: cover property (@(posedge core_clk) disable iff (!rst_n)
    rx_invert);
  c_blink: cover property (@(posedge core_clk) disable iff (!rst_n)
    blink_en && autoneg_busy);

endmodule

// File: testbench/tbr_regs_tb.sv
/*
  self-checking bench for tbr_regs: reset values, legacy write blocking,
  random register and pin traffic, indicator blink, repeater strap.
  assumes one-cycle strobes and read data valid in the cycle after the
  read strobe is taken; pins settle within six cycles.
*/
module tbr_regs_tb import tbr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        core_clk, rst_n, mgmt_wr, mgmt_rd;
  logic [4:0]  mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, rv, w, s, seed;
  logic        rev, pkt, strap, s100, an_en, an_busy, fdx, lpbk, lg_in;
  logic        inv, ser, lpe, lg, f10, hb, lsq, jab, ind;
  int          fails, checks_done, chg;

  // blink shortened so a few periods fit in a short window
  tbr_regs #(.BLINK_CYCLES(4)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .rx_pol_reversed(rev), .rx_pkt_active(pkt),
    .repeater_strap(strap), .speed_100(s100), .autoneg_en(an_en),
    .autoneg_busy(an_busy), .full_duplex(fdx), .endec_loopback(lpbk),
    .link_good_in(lg_in), .rx_invert(inv), .serial_path(ser),
    .link_pulse_tx_en(lpe), .link_good(lg), .force_10(f10),
    .heartbeat_test(hb), .low_squelch(lsq), .jabber_en(jab),
    .third_indicator_output(ind));

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // status image: polarity flag follows the line, serial bit as written
  function automatic logic [15:0] exp_st(input logic r, input logic sb);
    return {5'h00, ~r, sb, 9'h000};
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // one-cycle write strobe, dropped on the next falling edge
  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    mgmt_wr = 1'b1;
    mgmt_addr = a;
    mgmt_wdata = d;
    @(negedge core_clk);
    mgmt_wr = 1'b0;
  endtask

  // read data is taken in the cycle after the strobe edge
  task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge core_clk);
    mgmt_rd = 1'b1;
    mgmt_addr = a;
    @(negedge core_clk);
    mgmt_rd = 1'b0;
    d = mgmt_rdata;
  endtask

  // counts indicator changes over 40 cycles
  task automatic count_chg(output int n);
    logic l;
    n = 0;
    l = ind;
    repeat (40) begin
      @(negedge core_clk);
      if (ind !== l) n++;
      l = ind;
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // watchdog: the sequence needs a few thousand cycles at most
  // ----------------------------------------------------------------------
  initial begin
    #100000;
    fails++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = '0;
    {rev, pkt, strap, s100, an_en, an_busy, fdx, lpbk, lg_in} = '0;
    fails = 0;
    checks_done = 0;
    seed = 16'h0056;
    cyc(10);
    rst_n = 1'b1;
    cyc(6);
    // values after reset, heartbeat follows the inverse strap
    reg_rd(TBR_ADDR_CONFIG, rv);
    check("cfg_rst", rv, 16'h00b9);
    reg_rd(TBR_ADDR_STATUS, rv);
    check("st_rst", rv, 16'h0400);
    // legacy mode keeps blink and polarity disable from being written
    reg_wr(TBR_ADDR_CONFIG, 16'hffff);
    reg_rd(TBR_ADDR_CONFIG, rv);
    check("cfg_legacy", rv, 16'h00bd);
    rev = 1'b1;
    pkt = 1'b1;
    cyc(6);
    check("inv_legacy", inv, 1'b1);
    reg_rd(TBR_ADDR_STATUS, rv);
    check("st_rev", rv, 16'h0000);
    // a write to a neighbouring address leaves the pair alone
    reg_wr(5'h1d, 16'h0000);
    reg_rd(TBR_ADDR_CONFIG, rv);
    check("cfg_unmapped", rv, 16'h00bd);
    reg_wr(TBR_ADDR_CONFIG, 16'h0039);
    // random register contents and pin states, legacy mode off
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      s = seed;
      seed = lfsr(seed);
      w = (seed & 16'hff7f) | 16'h0008;
      seed = lfsr(seed);
      {rev, pkt, s100, an_en, fdx, lpbk, lg_in} = seed[6:0];
      reg_wr(TBR_ADDR_STATUS, s);
      reg_wr(TBR_ADDR_CONFIG, w);
      cyc(6);
      reg_rd(TBR_ADDR_CONFIG, rv);
      check("cfg", rv, {8'h00, w[7:0]});
      reg_rd(TBR_ADDR_STATUS, rv);
      check("st", rv, exp_st(rev, s[9]));
      check("f10", f10, !w[5] && s100 && an_en);
      check("hb", hb, w[4] && !fdx);
      check("lsq", lsq, w[2]);
      if (!s100) begin
        check("ser", ser, s[9]);
        check("lpe", lpe, w[5]);
        check("lg", lg, w[5] ? lg_in : 1'b1);
        check("jab", jab, w[0] || !(fdx || lpbk));
        if (pkt || w[1]) begin
          check("inv", inv, !w[1] && rev && pkt);
        end
      end else begin
        check("ser100", ser, 1'b0);
        if (!an_en) check("lg100", lg, lg_in);
      end
    end
    // indicator blinks during negotiation only when enabled
    {s100, lg_in, an_busy} = 3'b011;
    reg_wr(TBR_ADDR_CONFIG, 16'h0079);
    cyc(6);
    count_chg(chg);
    check("blink", chg > 3, 1'b1);
    reg_wr(TBR_ADDR_CONFIG, 16'h0039);
    cyc(6);
    count_chg(chg);
    check("steady", chg[15:0], 16'h0000);
    // repeater mode holds heartbeat enable clear
    strap = 1'b1;
    cyc(6);
    reg_wr(TBR_ADDR_CONFIG, 16'h0039);
    cyc(6);
    reg_rd(TBR_ADDR_CONFIG, rv);
    check("cfg_rep", rv, 16'h0029);
    check("hb_rep", hb, 1'b0);
    // second reset with the strap high
    rst_n = 1'b0;
    cyc(10);
    rst_n = 1'b1;
    cyc(6);
    reg_rd(TBR_ADDR_CONFIG, rv);
    check("cfg_rst2", rv, 16'h00a9);
    end_sim();
  end
endmodule
